// >>> adc_analog_model.sv
// Analog side of the converter: channel voltages and the core result.
`timescale 1ns/100ps
module adc_analog_model (
  input wire clock,
  input wire [3:0] analog_channel_pins,
  input wire [3:0] pin_out,
  input wire [3:0] pin_oe,
  output reg [7:0] converter_result,
  output wire [3:0] pin_in
);
  // Released pins show a pattern, never the last driven level.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & 4'ha);
  // ==========================================
  // Channel voltages: ground, full scale, two mid values.
  always @(posedge clock) begin
    case (analog_channel_pins)
      4'h1: converter_result <= 8'h00;
      4'h2: converter_result <= 8'hff;
      4'h4: converter_result <= 8'h5a;
      4'h8: converter_result <= 8'ha5;
      default: converter_result <= ~converter_result;
    endcase
  end
endmodule

// >>> adc_seq_map.vh
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
`define STATUS_CONTROL_OFFSET 12'h03c
`define DATA_OFFSET 12'h040
`define CLOCK_OFFSET 12'h044
`define PIN_STATE_OFFSET 12'h048
`define COMPLETE_BIT 7
`define INTERRUPT_ENABLE_BIT 6
`define CONTINUOUS_BIT 5
`define CLOCK_SOURCE_BIT 3
`define STATUS_CONTROL_RESET 8'h1f
`define CLOCK_RESET 8'h00
`define CHANNEL_OFF 5'h1f
`define CONVERT_CYCLES 5'h10
`endif

// >>> adc_sequencing_control.v
// Sequencing control of the eight-bit multiplexed converter with an AHB-Lite register slave.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
`include "adc_seq_map.vh"

// Behaviour
// - The selected channel pin is forced to act as converter input.
// - Port data and direction writes do not disturb the selected pin.
// - Port read of selected pin gives zero, or the data latch when direction is one.
// - Unselected channel pins stay ordinary general-purpose port pins.
// - At most one of four channel pins feeds the converter input; none for channel codes above three.
// - Result is eight bits; full scale codes all ones, ground all zeros.
// - Each status and control write outside stop mode, with channel field not all ones, starts a conversion lasting 16 to 17 converter clocks.
// - On completion the result loads and, in the same cycle, the flag sets or interrupt or transfer request rises.
// - Continuous mode overwrites the data register after every conversion.
// - Continuous conversions repeat until software clears the continuous bit.
// - Complete flag stays set until status write or data register read.
// - With interrupts enabled and flag bit zero, each conversion raises an interrupt.
// - With interrupts enabled and flag bit one, a transfer request is raised instead.
// - With interrupts enabled, the flag bit is not a done indicator.
// - Entering stop mode makes the converter inactive and aborts any conversion.
// - After stop mode ends, conversions can resume.
// - Channel field all ones turns the converter off.
// - With continuous bit clear, each start gives a single conversion.
// - Prescaler divides by 1, 2, 4 or 8 from bits 6:5, or by 16 when its top bit is one.
// - Clock source bit picks bus clock when one, oscillator clock when zero.
module adc_sequencing_control #(
  parameter RESULT_WIDTH = 8,
  parameter CHANNELS = 4
) (
  input wire clock,
  input wire reset,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire oscillator_output_clock,
  input wire stop_mode,
  input wire [RESULT_WIDTH-1:0] converter_result,
  input wire [CHANNELS-1:0] port_data_latch,
  input wire [CHANNELS-1:0] port_direction,
  input wire [CHANNELS-1:0] pin_in,
  output reg [CHANNELS-1:0] pin_out,
  output reg [CHANNELS-1:0] pin_oe,
  output reg [CHANNELS-1:0] port_read_value,
  output reg [CHANNELS-1:0] analog_channel_pins,
  output reg converter_power,
  output reg sample_strobe,
  output reg converter_interrupt,
  output reg transfer_request
);

  // ==========================================================
  // Sequencer states
  localparam STATE_IDLE = 1'b0;
  localparam STATE_CONVERT = 1'b1;

  // ==========================================================
  // Registers and their next values
  reg [11:0] addr_reg;
  reg wr_reg;
  reg rd_reg;
  reg [7:0] status_control_reg;
  reg [7:0] status_control_next;
  reg [7:0] clock_reg;
  reg [7:0] clock_next;
  reg [RESULT_WIDTH-1:0] data_reg;
  reg [RESULT_WIDTH-1:0] data_next;
  reg complete_reg;
  reg complete_next;
  reg [1:0] osc_sync_reg;
  reg [CHANNELS-1:0] pin_sync1_reg;
  reg [CHANNELS-1:0] pin_sync2_reg;
  reg osc_prev_reg;
  reg [3:0] prescale_reg;
  reg [3:0] prescale_next;
  reg tick_reg;
  reg tick_next;
  reg state_reg;
  reg state_next;
  reg [4:0] count_reg;
  reg [4:0] count_next;
  reg interrupt_next;
  reg request_next;
  reg strobe_next;
  reg power_next;
  reg [31:0] read_mux;
  wire accept;
  wire status_write;
  wire clock_write;
  wire data_read;
  wire [4:0] channel_select_field;
  wire [4:0] written_channel;
  wire converter_off;
  wire start_off;
  wire channel_valid;
  wire [CHANNELS-1:0] selected_onehot;
  wire [CHANNELS-1:0] pin_out_next;
  wire [CHANNELS-1:0] pin_oe_next;
  wire [CHANNELS-1:0] read_value_next;
  wire source_edge;
  wire [3:0] divide_mask;
  wire done;
  wire finish;
  wire interrupt_enable;
  wire flag_bit;

  // ==========================================================
  // Decoding of bus transfers and control fields
  assign accept = hsel && hready && htrans[1];
  assign status_write = wr_reg && (addr_reg == `STATUS_CONTROL_OFFSET);
  assign clock_write = wr_reg && (addr_reg == `CLOCK_OFFSET);
  assign data_read = rd_reg && (addr_reg == `DATA_OFFSET);
  assign channel_select_field = status_control_reg[4:0];
  assign written_channel = hwdata[4:0];
  assign converter_off = (channel_select_field == `CHANNEL_OFF);
  assign start_off = (written_channel == `CHANNEL_OFF);
  assign channel_valid = (channel_select_field < CHANNELS);
  assign interrupt_enable = status_control_reg[`INTERRUPT_ENABLE_BIT];
  assign flag_bit = status_control_reg[`COMPLETE_BIT];

  // ==========================================================
  // Channel selection and pin takeover
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : pin_ctl
      assign selected_onehot[g] = channel_valid && (channel_select_field == g);
      assign pin_out_next[g] = selected_onehot[g] ? 1'b0 : port_data_latch[g];
      assign pin_oe_next[g] = selected_onehot[g] ? 1'b0 : port_direction[g];
      assign read_value_next[g] = selected_onehot[g] ? (port_direction[g] & port_data_latch[g]) :
        (port_direction[g] ? port_data_latch[g] : pin_sync2_reg[g]);
    end
  endgenerate

  always @(posedge clock) begin
    if (reset) begin
      pin_out <= {CHANNELS{1'b0}};
      pin_oe <= {CHANNELS{1'b0}};
      port_read_value <= {CHANNELS{1'b0}};
      analog_channel_pins <= {CHANNELS{1'b0}};
      pin_sync1_reg <= {CHANNELS{1'b0}};
      pin_sync2_reg <= {CHANNELS{1'b0}};
    end else begin
      pin_out <= pin_out_next;
      pin_oe <= pin_oe_next;
      port_read_value <= read_value_next;
      analog_channel_pins <= selected_onehot;
      pin_sync1_reg <= pin_in;
      pin_sync2_reg <= pin_sync1_reg;
    end
  end

  // ==========================================================
  // Converter clock source and prescaler
  assign source_edge = clock_reg[`CLOCK_SOURCE_BIT] ? 1'b1 : (osc_sync_reg[1] & ~osc_prev_reg);
  assign divide_mask = clock_reg[7] ? 4'hf : ((4'h1 << clock_reg[6:5]) - 4'h1);

  always @* begin
    prescale_next = prescale_reg;
    tick_next = 1'b0;
    if (status_write) begin
      prescale_next = 4'h0;
    end else if (source_edge) begin
      if ((prescale_reg & divide_mask) == divide_mask) begin
        prescale_next = 4'h0;
        tick_next = 1'b1;
      end else begin
        prescale_next = prescale_reg + 4'h1;
      end
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      osc_sync_reg <= 2'b00;
      osc_prev_reg <= 1'b0;
      prescale_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], oscillator_output_clock};
      osc_prev_reg <= osc_sync_reg[1];
      prescale_reg <= prescale_next;
      tick_reg <= tick_next;
    end
  end

  // ==========================================================
  // Conversion sequencing
  assign done = (state_reg == STATE_CONVERT) && tick_reg && (count_reg == `CONVERT_CYCLES - 5'h01);
  assign finish = done && !stop_mode;

  always @* begin
    state_next = state_reg;
    count_next = count_reg;
    strobe_next = 1'b0;
    power_next = ~converter_off & ~stop_mode;
    case (state_reg)
      STATE_IDLE: begin
        count_next = 5'h00;
        if (!stop_mode && status_write && !start_off) begin
          state_next = STATE_CONVERT;
        end
      end
      STATE_CONVERT: begin
        if (stop_mode) begin
          state_next = STATE_IDLE;
          count_next = 5'h00;
        end else if (status_write) begin
          state_next = start_off ? STATE_IDLE : STATE_CONVERT;
          count_next = 5'h00;
        end else if (converter_off) begin
          state_next = STATE_IDLE;
          count_next = 5'h00;
        end else if (done) begin
          state_next = status_control_reg[`CONTINUOUS_BIT] ? STATE_CONVERT : STATE_IDLE;
          count_next = 5'h00;
          strobe_next = 1'b1;
        end else if (tick_reg) begin
          count_next = count_reg + 5'h01;
        end
      end
      default: begin
        state_next = STATE_IDLE;
        count_next = 5'h00;
      end
    endcase
  end

  always @* begin
    data_next = data_reg;
    complete_next = complete_reg;
    interrupt_next = converter_interrupt;
    request_next = transfer_request;
    if (finish) begin
      data_next = converter_result;
    end
    if (finish && !interrupt_enable) begin
      complete_next = 1'b1;
    end else if (status_write || data_read) begin
      complete_next = 1'b0;
    end
    if (finish && interrupt_enable) begin
      interrupt_next = ~flag_bit;
      request_next = flag_bit;
    end else if (status_write || data_read) begin
      interrupt_next = 1'b0;
      request_next = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      state_reg <= STATE_IDLE;
      count_reg <= 5'h00;
      data_reg <= {RESULT_WIDTH{1'b0}};
      complete_reg <= 1'b0;
      converter_interrupt <= 1'b0;
      transfer_request <= 1'b0;
      sample_strobe <= 1'b0;
      converter_power <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      data_reg <= data_next;
      complete_reg <= complete_next;
      converter_interrupt <= interrupt_next;
      transfer_request <= request_next;
      sample_strobe <= strobe_next;
      converter_power <= power_next;
    end
  end

  // ==========================================================
  // Register file and bus responses
  always @* begin
    read_mux = 32'h0000_0000;
    case (addr_reg)
      `STATUS_CONTROL_OFFSET: begin
        read_mux[7:0] = interrupt_enable ? status_control_reg : {complete_reg, status_control_reg[6:0]};
      end
      `DATA_OFFSET: begin
        read_mux[RESULT_WIDTH-1:0] = data_reg;
      end
      `CLOCK_OFFSET: begin
        read_mux[7:0] = clock_reg;
      end
      `PIN_STATE_OFFSET: begin
        read_mux[CHANNELS-1:0] = port_read_value;
        read_mux[8] = state_reg;
      end
      default: begin
        read_mux = 32'h0000_0000;
      end
    endcase
  end

  always @* begin
    status_control_next = status_control_reg;
    clock_next = clock_reg;
    if (status_write) begin
      status_control_next = hwdata[7:0];
    end
    if (clock_write) begin
      clock_next = hwdata[7:0];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      addr_reg <= 12'h000;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      status_control_reg <= `STATUS_CONTROL_RESET;
      clock_reg <= `CLOCK_RESET;
    end else begin
      hresp <= 1'b0;
      hreadyout <= 1'b1;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      if (accept) begin
        addr_reg <= {haddr[11:2], 2'b00};
        wr_reg <= hwrite;
        rd_reg <= ~hwrite;
        if (!hwrite) begin
          hreadyout <= 1'b0;
        end
      end
      if (rd_reg) begin
        hrdata <= read_mux;
      end
      status_control_reg <= status_control_next;
      clock_reg <= clock_next;
    end
  end

endmodule

// >>> adc_sequencing_control_checker.sv
// Port assertions of the converter sequencing control.
`timescale 1ns/100ps
module adc_sequencing_control_checker (
  input wire clock,
  input wire reset,
  input wire stop_mode,
  input wire [3:0] port_data_latch,
  input wire [3:0] port_direction,
  input wire [3:0] pin_oe,
  input wire [3:0] port_read_value,
  input wire [3:0] analog_channel_pins,
  input wire converter_power,
  input wire sample_strobe,
  input wire converter_interrupt
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================
  // Pins and conversions.
  property p_taken; (pin_oe & analog_channel_pins) == 4'h0; endproperty
  a_taken: assert property (p_taken) else $error("selected pin driven");
  property p_one; $onehot0(analog_channel_pins); endproperty
  a_one: assert property (p_one) else $error("several pins routed");
  property p_unsel; !$past(reset) |-> ((pin_oe ^ $past(port_direction)) & ~analog_channel_pins) == 4'h0; endproperty
  a_unsel: assert property (p_unsel) else $error("free pin not port driven");
  property p_read; !$past(reset) |-> (analog_channel_pins & (port_read_value ^
    ($past(port_direction) & $past(port_data_latch)))) == 4'h0; endproperty
  a_read: assert property (p_read) else $error("selected pin read wrong");
  property p_stop; stop_mode |=> !converter_power; endproperty
  a_stop: assert property (p_stop) else $error("powered in stop");
  property p_abort; stop_mode [*2] |=> !sample_strobe; endproperty
  a_abort: assert property (p_abort) else $error("completion in stop");
  property p_gap; sample_strobe |=> !sample_strobe [*8]; endproperty
  a_gap: assert property (p_gap) else $error("conversion too short");
  property p_irq; $rose(converter_interrupt) |-> sample_strobe; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without completion");
endmodule

// >>> test_adc_sequencing_control.sv
// Self-checking bench of the converter sequencing control.
`timescale 1ns/100ps
module test_adc_sequencing_control;
  reg clock = 1'b0;
  reg reset = 1'b1;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg stop_mode = 1'b0;
  reg oscillator_output_clock = 1'b0;
  reg [1:0] htrans = 2'h0;
  reg [11:0] haddr = 12'h0;
  reg [31:0] hwdata = 32'h0;
  reg [3:0] port_data_latch = 4'hf;
  reg [3:0] port_direction = 4'hf;
  wire [2:0] hsize = 3'h2;
  wire hready, hresp, converter_power, sample_strobe, converter_interrupt, transfer_request;
  wire [31:0] hrdata;
  wire [7:0] converter_result;
  wire [3:0] pin_in, pin_out, pin_oe, port_read_value, analog_channel_pins;
  integer n_fail = 0;
  integer n_checks = 0;
  integer n;
  reg [31:0] q;
  adc_sequencing_control i_adc_sequencing_control (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .oscillator_output_clock(oscillator_output_clock), .stop_mode(stop_mode),
    .converter_result(converter_result), .port_data_latch(port_data_latch), .port_direction(port_direction),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .port_read_value(port_read_value),
    .analog_channel_pins(analog_channel_pins), .converter_power(converter_power), .sample_strobe(sample_strobe),
    .converter_interrupt(converter_interrupt), .transfer_request(transfer_request));
  adc_analog_model i_adc_analog_model (.clock(clock), .analog_channel_pins(analog_channel_pins), .pin_out(pin_out),
    .pin_oe(pin_oe), .converter_result(converter_result), .pin_in(pin_in));
  always #20 clock = ~clock;
  always #100 oscillator_output_clock = ~oscillator_output_clock;
  // ==========================================
  // Shared tasks.
  task chk(input string what, input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= a;
      htrans <= 2'h2;
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hready !== 1'b1);
      q = hrdata;
      chk("hresp", hresp, 32'h0);
    end
  endtask
  task wait_done;
    begin
      n = 0;
      while (sample_strobe !== 1'b1 && n < 40) begin
        @(posedge clock);
        n = n + 1;
      end
    end
  endtask
  task count_done(input integer cyc);
    begin
      n = 0;
      repeat (cyc) begin
        @(posedge clock);
        if (sample_strobe === 1'b1) n = n + 1;
      end
    end
  endtask
  // ==========================================
  // Scenarios.
  task t_single;
    begin
      bus(1'b0, 12'h03c, 32'h0);
      chk("status reset", q, 32'h1f);
      chk("power", converter_power, 1'b0);
      bus(1'b0, 12'h044, 32'h0);
      chk("clock reset", q, 32'h0);
      bus(1'b1, 12'h100, 32'hff);
      bus(1'b0, 12'h100, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(1'b1, 12'h044, 32'h8);
      bus(1'b1, 12'h03c, 32'h1);
      wait_done;
      chk("conv time", n >= 16 && n <= 19, 1);
      chk("pin oe", pin_oe, 4'hd);
      chk("pin out", pin_out, 4'hd);
      bus(1'b0, 12'h03c, 32'h0);
      chk("flag set", q, 32'h81);
      bus(1'b0, 12'h040, 32'h0);
      chk("full scale", q, 32'hff);
      bus(1'b0, 12'h03c, 32'h0);
      chk("flag clear", q, 32'h01);
      port_direction <= 4'h5;
      port_data_latch <= 4'h3;
      repeat (4) @(posedge clock);
      chk("mixed oe", pin_oe, 4'h5);
      chk("mixed out", pin_out, 4'h1);
      bus(1'b0, 12'h048, 32'h0);
      chk("port read", q, 32'h9);
      port_direction <= 4'hf;
      port_data_latch <= 4'hf;
      count_done(60);
      chk("single", n, 0);
      $display("single done");
    end
  endtask
  task t_cont;
    begin
      bus(1'b1, 12'h03c, 32'h20);
      count_done(100);
      chk("repeats", n >= 5 && n <= 6, 1);
      bus(1'b0, 12'h040, 32'h0);
      chk("overwrite", q, 32'h0);
      bus(1'b1, 12'h03c, 32'h1f);
      count_done(60);
      chk("halted", n, 0);
      $display("continuous done");
    end
  endtask
  task t_irq;
    begin
      bus(1'b1, 12'h03c, 32'h43);
      wait_done;
      @(posedge clock);
      chk("irq", converter_interrupt, 1'b1);
      chk("no dreq", transfer_request, 1'b0);
      bus(1'b0, 12'h03c, 32'h0);
      chk("flag unused", q, 32'h43);
      bus(1'b0, 12'h040, 32'h0);
      chk("ch3", q, 32'ha5);
      @(posedge clock);
      chk("irq clear", converter_interrupt, 1'b0);
      bus(1'b1, 12'h03c, 32'hc3);
      wait_done;
      @(posedge clock);
      chk("dreq", transfer_request, 1'b1);
      chk("no irq", converter_interrupt, 1'b0);
      bus(1'b1, 12'h03c, 32'h1f);
      @(posedge clock);
      chk("dreq clear", transfer_request, 1'b0);
      $display("interrupt done");
    end
  endtask
  task t_stop;
    begin
      bus(1'b1, 12'h03c, 32'h22);
      repeat (5) @(posedge clock);
      stop_mode <= 1'b1;
      count_done(60);
      chk("aborted", n, 0);
      chk("stop power", converter_power, 1'b0);
      stop_mode <= 1'b0;
      bus(1'b1, 12'h03c, 32'h02);
      wait_done;
      chk("resumed", n < 40, 1);
      bus(1'b0, 12'h040, 32'h0);
      chk("ch2", q, 32'h5a);
      $display("stop done");
    end
  endtask
  task t_clk;
    begin
      bus(1'b1, 12'h044, 32'h28);
      bus(1'b1, 12'h03c, 32'h1);
      wait_done;
      chk("div two", n >= 32 && n <= 36, 1);
      bus(1'b1, 12'h044, 32'h0);
      bus(1'b1, 12'h03c, 32'h1);
      count_done(60);
      chk("osc slow", n, 0);
      count_done(60);
      chk("osc done", n, 1);
      $display("clock done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    #200000;
    n_fail = n_fail + 1;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_single;
    t_cont;
    t_irq;
    t_stop;
    t_clk;
    tally_and_finish;
  end
endmodule
bind adc_sequencing_control adc_sequencing_control_checker i_adc_sequencing_control_checker (.clock(clock),
  .reset(reset), .stop_mode(stop_mode), .port_data_latch(port_data_latch), .port_direction(port_direction),
  .pin_oe(pin_oe), .port_read_value(port_read_value), .analog_channel_pins(analog_channel_pins),
  .converter_power(converter_power), .sample_strobe(sample_strobe), .converter_interrupt(converter_interrupt));
